/* File: shared/cal_pkg.sv */
// Shared constants and carriers for the range/error calibration command decoder.
// Assumes the CAN controller hands over whole received frames, one per valid cycle.
package cal_pkg;

    localparam int NUM_IN = 4;
    localparam int MAG_W = 24;
    localparam int VAL_W = 25;
    localparam int PGN_W = 18;
    localparam int LEN_W = 4;
    localparam int MSG_BYTES = 6;

    // Frame layout, byte index from the first data byte
    localparam int BYTE_CMD = 0;
    localparam int BYTE_OPT = 1;
    localparam int BYTE_SIGN = 2;
    localparam int BYTE_MAG_HI = 3;
    localparam int BYTE_MAG_MID = 4;
    localparam int BYTE_MAG_LO = 5;

    // Option byte fields
    localparam int MAXSEL_BIT = 4;
    localparam int MASK_W = 4;

    localparam logic [LEN_W-1:0] MSG_LEN = 4'h6;
    localparam logic [PGN_W-1:0] PGN_DEFAULT = 18'h0ffa5;

    // Command codes
    localparam logic [7:0] CMD_RANGE_SET = 8'ha5;
    localparam logic [7:0] CMD_RANGE_SAVE = 8'h5a;
    localparam logic [7:0] CMD_ERROR_SET = 8'ha6;
    localparam logic [7:0] CMD_ERROR_SAVE = 8'h6a;

    // Sign byte codes
    localparam logic [7:0] SIGN_POS = 8'h00;
    localparam logic [7:0] SIGN_NEG = 8'h01;

    typedef logic signed [VAL_W-1:0] setpt_t;

    // Setpoints after reset
    localparam setpt_t RANGE_MIN_RST = 25'h0000000;
    localparam setpt_t RANGE_MAX_RST = 25'h0000000;
    localparam setpt_t ERROR_MIN_RST = 25'h0000000;
    localparam setpt_t ERROR_MAX_RST = 25'h0000000;

    typedef enum logic [2:0] {
        OP_NONE = 3'b000,
        OP_RANGE_SET = 3'b001,
        OP_RANGE_SAVE = 3'b010,
        OP_ERROR_SET = 3'b011,
        OP_ERROR_SAVE = 3'b100
    } cal_op_e;

    typedef struct packed {
        logic valid;
        logic [PGN_W-1:0] pgn;
        logic [LEN_W-1:0] len;
        logic [MSG_BYTES-1:0][7:0] data;
    } can_msg_s;

    typedef struct packed {
        cal_op_e op;
        logic maxsel;
        logic [MASK_W-1:0] mask;
        setpt_t value;
    } cal_req_s;

    typedef struct packed {
        setpt_t range_min;
        setpt_t range_max;
        setpt_t error_min;
        setpt_t error_max;
    } chan_setpt_s;

endpackage

/* File: rtl/cal_msg_decode.sv */
// Frame decoder: filters by group, checks length, command and sign, forms the signed value.
// Assumes a frame is presented for one cycle with valid high.
`timescale 1ns/1ps
`default_nettype none
module cal_msg_decode
    import cal_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // Received frame
    input wire can_msg_s msg,
    input wire logic [PGN_W-1:0] pgn_sel,
    // Decoded request
    output cal_req_s req_q,
    output logic drop_q
);

    logic [7:0] cmd;
    logic [7:0] opt;
    logic [7:0] sgn;
    logic [MAG_W-1:0] mag;
    logic for_us;
    logic is_save;
    logic sign_ok;
    logic take;
    cal_op_e op_d;
    setpt_t mag_s;
    setpt_t val_d;

    assign cmd = msg.data[BYTE_CMD];
    assign opt = msg.data[BYTE_OPT];
    assign sgn = msg.data[BYTE_SIGN];
    assign mag = {msg.data[BYTE_MAG_HI], msg.data[BYTE_MAG_MID], msg.data[BYTE_MAG_LO]};
    assign for_us = msg.valid && (msg.pgn == pgn_sel);

    always_comb begin
        case (cmd)
            CMD_RANGE_SET: op_d = OP_RANGE_SET;
            CMD_RANGE_SAVE: op_d = OP_RANGE_SAVE;
            CMD_ERROR_SET: op_d = OP_ERROR_SET;
            CMD_ERROR_SAVE: op_d = OP_ERROR_SAVE;
            default: op_d = OP_NONE;
        endcase
    end

    assign is_save = (op_d == OP_RANGE_SAVE) || (op_d == OP_ERROR_SAVE);
    assign sign_ok = (sgn == SIGN_POS) || (sgn == SIGN_NEG);
    assign mag_s = setpt_t'({1'b0, mag});
    assign val_d = (sgn == SIGN_NEG) ? -mag_s : mag_s;
    // Saves ignore bytes 1..5, sets need a valid sign
    assign take = for_us && (msg.len == MSG_LEN) && (op_d != OP_NONE) && (is_save || sign_ok);

    always_ff @(posedge clk) begin
        if (rst) begin
            req_q <= '0;
        end else if (ce) begin
            req_q.op <= take ? op_d : OP_NONE;
            req_q.maxsel <= is_save ? 1'b0 : opt[MAXSEL_BIT];
            req_q.mask <= is_save ? '0 : opt[MASK_W-1:0];
            req_q.value <= is_save ? '0 : val_d;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            drop_q <= 1'b0;
        end else if (ce) begin
            drop_q <= for_us && !take;
        end
    end

endmodule
`default_nettype wire

/* File: rtl/cal_chan_setpt.sv */
// One input's range and error setpoints with their bound checks.
// Assumes capacity and magnitudes share the input's configured weight unit.
`timescale 1ns/1ps
`default_nettype none
module cal_chan_setpt
    import cal_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // Request and configuration
    input wire cal_req_s req,
    input wire logic sel,
    input wire logic [MAG_W-1:0] cap,
    // Stored setpoints and outcome
    output chan_setpt_s sp_q,
    output logic acc_q,
    output logic rej_q
);

    logic is_range;
    logic hit;
    logic in_bounds;
    setpt_t pos_cap;
    setpt_t neg_cap;
    setpt_t lo;
    setpt_t hi;

    assign is_range = (req.op == OP_RANGE_SET);
    assign hit = sel && (is_range || (req.op == OP_ERROR_SET));
    // Raw magnitudes compared in the input's own unit
    assign pos_cap = setpt_t'({1'b0, cap});
    assign neg_cap = -pos_cap;

    always_comb begin
        if (req.maxsel) begin
            lo = is_range ? sp_q.range_min : sp_q.error_min;
            hi = pos_cap;
        end else begin
            lo = neg_cap;
            hi = is_range ? sp_q.range_max : sp_q.error_max;
        end
    end

    assign in_bounds = (req.value >= lo) && (req.value <= hi);

    // Out-of-bounds values leave all setpoints untouched
    always_ff @(posedge clk) begin
        if (rst) begin
            sp_q.range_min <= RANGE_MIN_RST;
            sp_q.range_max <= RANGE_MAX_RST;
            sp_q.error_min <= ERROR_MIN_RST;
            sp_q.error_max <= ERROR_MAX_RST;
        end else if (ce && hit && in_bounds) begin
            case ({is_range, req.maxsel})
                2'b10: sp_q.range_min <= req.value;
                2'b11: sp_q.range_max <= req.value;
                2'b00: sp_q.error_min <= req.value;
                default: sp_q.error_max <= req.value;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            acc_q <= 1'b0;
            rej_q <= 1'b0;
        end else if (ce) begin
            acc_q <= hit && in_bounds;
            rej_q <= hit && !in_bounds;
        end
    end

endmodule
`default_nettype wire

/* File: rtl/cal_cmd_ctrl.sv */
// Range and error calibration command handler for four strain inputs.
// Assumes frames arrive decoded from CAN; commit pulses drive a separate store writer.
//
// How it works
// - Calibration frames are six bytes: command, option, sign, three magnitude bytes.
// - Range codes: 0xa5 sets a value, 0x5a exits and commits settings.
// - Error codes: 0xa6 sets a value, 0x6a exits and commits settings.
// - Range option bit 4 clear picks minimum, set picks maximum.
// - Error option bit 4 clear picks minimum, set picks maximum.
// - New range minimum must lie between minus capacity and current range maximum.
// - New range maximum must lie between current range minimum and capacity.
// - New error minimum must lie between minus capacity and current error maximum.
// - New error maximum must lie between current error minimum and capacity.
// - Magnitude is 24-bit unsigned, first byte most significant.
// - Sign byte 0x00 positive, 0x01 negative, applied to the magnitude.
// - Range save ignores the other five bytes and only commits.
// - Error save ignores the other five bytes and only commits.
// - Magnitudes are in the input's configured weight unit.
// - Frames are decoded only from the selected group, default 0xffa5.
// - Option low nibble is a per-input mask; several inputs per frame.
`timescale 1ns/1ps
`default_nettype none
module cal_cmd_ctrl
    import cal_pkg::*;
(
    // Clock, reset, enable
    input wire logic CLK,
    input wire logic RST,
    input wire logic CE,
    // Received frames
    input wire can_msg_s MSG,
    input wire logic [PGN_W-1:0] PGN_SEL,
    // Per-input capacity in its weight unit
    input wire logic [NUM_IN-1:0][MAG_W-1:0] MAX_CAP,
    // Stored setpoints
    output wire chan_setpt_s [NUM_IN-1:0] SETPOINTS,
    // Outcome of each set frame, per input; one flag for each dropped frame
    output wire logic [NUM_IN-1:0] ACCEPT,
    output wire logic [NUM_IN-1:0] REJECT,
    output logic IGNORED,
    // Calibration session and commit
    output logic RANGE_CAL_ACTIVE,
    output logic ERROR_CAL_ACTIVE,
    output logic SAVE_RANGE,
    output logic SAVE_ERROR
);

    cal_req_s req;
    logic drop;
    logic msg_ours;

    cal_msg_decode u_decode (
        .clk(CLK),
        .rst(RST),
        .ce(CE),
        .msg(MSG),
        .pgn_sel(PGN_SEL),
        .req_q(req),
        .drop_q(drop)
    );

    genvar gi;
    generate
        for (gi = 0; gi < NUM_IN; gi++) begin : g_chan
            cal_chan_setpt u_chan (
                .clk(CLK),
                .rst(RST),
                .ce(CE),
                .req(req),
                .sel(req.mask[gi]),
                .cap(MAX_CAP[gi]),
                .sp_q(SETPOINTS[gi]),
                .acc_q(ACCEPT[gi]),
                .rej_q(REJECT[gi])
            );
        end
    endgenerate

    // Commit pulses, aligned with the per-input outcome
    always_ff @(posedge CLK) begin
        if (RST) begin
            SAVE_RANGE <= 1'b0;
            SAVE_ERROR <= 1'b0;
        end else if (CE) begin
            SAVE_RANGE <= (req.op == OP_RANGE_SAVE);
            SAVE_ERROR <= (req.op == OP_ERROR_SAVE);
        end
    end

    // Session flags: opened by a set frame, closed by its save
    always_ff @(posedge CLK) begin
        if (RST) begin
            RANGE_CAL_ACTIVE <= 1'b0;
        end else if (CE) begin
            if (req.op == OP_RANGE_SET) begin
                RANGE_CAL_ACTIVE <= 1'b1;
            end else if (req.op == OP_RANGE_SAVE) begin
                RANGE_CAL_ACTIVE <= 1'b0;
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            ERROR_CAL_ACTIVE <= 1'b0;
        end else if (CE) begin
            if (req.op == OP_ERROR_SET) begin
                ERROR_CAL_ACTIVE <= 1'b1;
            end else if (req.op == OP_ERROR_SAVE) begin
                ERROR_CAL_ACTIVE <= 1'b0;
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            IGNORED <= 1'b0;
        end else if (CE) begin
            IGNORED <= drop;
        end
    end

    // Checks
    assign msg_ours = MSG.valid && (MSG.pgn == PGN_SEL);

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RST);

    a_pgn_filter_drop: assert property (
        CE && MSG.valid && (MSG.pgn != PGN_SEL)
        |=> (req.op == OP_NONE) && !drop
    ) else $error("frame from another group was decoded");

    a_bad_len_ignored: assert property (
        CE && msg_ours && (MSG.len != MSG_LEN)
        |=> ((req.op == OP_NONE) && drop) and (CE |=> IGNORED)
    ) else $error("frame of wrong length was not ignored");

    a_bad_cmd_ignored: assert property (
        CE && msg_ours && (MSG.data[BYTE_CMD] != CMD_RANGE_SET) && (MSG.data[BYTE_CMD] != CMD_RANGE_SAVE)
        && (MSG.data[BYTE_CMD] != CMD_ERROR_SET) && (MSG.data[BYTE_CMD] != CMD_ERROR_SAVE)
        |=> (req.op == OP_NONE) && drop
    ) else $error("unknown command was not ignored");

    a_range_set_decode: assert property (
        CE && msg_ours && (MSG.len == MSG_LEN) && (MSG.data[BYTE_CMD] == CMD_RANGE_SET)
        && (MSG.data[BYTE_SIGN] == SIGN_POS)
        |=> (req.op == OP_RANGE_SET)
    ) else $error("range set command not decoded");

    a_error_set_decode: assert property (
        CE && msg_ours && (MSG.len == MSG_LEN) && (MSG.data[BYTE_CMD] == CMD_ERROR_SET)
        && (MSG.data[BYTE_SIGN] == SIGN_NEG)
        |=> (req.op == OP_ERROR_SET)
    ) else $error("error set command not decoded");

    a_mag_positive: assert property (
        CE && msg_ours && (MSG.len == MSG_LEN) && (MSG.data[BYTE_CMD] == CMD_RANGE_SET)
        && (MSG.data[BYTE_SIGN] == SIGN_POS)
        |=> req.value == setpt_t'({1'b0, $past(MSG.data[BYTE_MAG_HI]), $past(MSG.data[BYTE_MAG_MID]),
            $past(MSG.data[BYTE_MAG_LO])})
    ) else $error("magnitude byte order wrong");

    a_mag_negative: assert property (
        CE && msg_ours && (MSG.len == MSG_LEN) && (MSG.data[BYTE_CMD] == CMD_ERROR_SET)
        && (MSG.data[BYTE_SIGN] == SIGN_NEG)
        |=> req.value == -setpt_t'({1'b0, $past(MSG.data[BYTE_MAG_HI]), $past(MSG.data[BYTE_MAG_MID]),
            $past(MSG.data[BYTE_MAG_LO])})
    ) else $error("negative sign not applied");

    a_option_maxsel: assert property (
        CE && msg_ours && (MSG.len == MSG_LEN) && (MSG.data[BYTE_CMD] == CMD_RANGE_SET)
        |=> (req.maxsel == $past(MSG.data[BYTE_OPT][MAXSEL_BIT]))
        && (req.mask == $past(MSG.data[BYTE_OPT][MASK_W-1:0]))
    ) else $error("option byte not carried to request");

    a_error_option_bits: assert property (
        CE && msg_ours && (MSG.len == MSG_LEN) && (MSG.data[BYTE_CMD] == CMD_ERROR_SET)
        |=> (req.maxsel == $past(MSG.data[BYTE_OPT][MAXSEL_BIT]))
        && (req.mask == $past(MSG.data[BYTE_OPT][MASK_W-1:0]))
    ) else $error("error option byte not carried to request");

    a_bad_sign_ignored: assert property (
        CE && msg_ours && (MSG.len == MSG_LEN) && (MSG.data[BYTE_SIGN] > SIGN_NEG)
        && ((MSG.data[BYTE_CMD] == CMD_RANGE_SET) || (MSG.data[BYTE_CMD] == CMD_ERROR_SET))
        |=> (req.op == OP_NONE) && drop
    ) else $error("set frame with bad sign byte was not ignored");

    a_range_save_decode: assert property (
        CE && msg_ours && (MSG.len == MSG_LEN) && (MSG.data[BYTE_CMD] == CMD_RANGE_SAVE)
        |=> (req.op == OP_RANGE_SAVE) && (req.mask == '0) && !drop
    ) else $error("range save not decoded");

    a_error_save_decode: assert property (
        CE && msg_ours && (MSG.len == MSG_LEN) && (MSG.data[BYTE_CMD] == CMD_ERROR_SAVE)
        |=> (req.op == OP_ERROR_SAVE) && (req.mask == '0) && !drop
    ) else $error("error save not decoded");

    a_range_save_pulse: assert property (
        CE && (req.op == OP_RANGE_SAVE)
        |=> SAVE_RANGE && !RANGE_CAL_ACTIVE && (ACCEPT == '0) && (SETPOINTS == $past(SETPOINTS))
    ) else $error("range save did more than commit");

    a_error_save_pulse: assert property (
        CE && (req.op == OP_ERROR_SAVE)
        |=> SAVE_ERROR && !ERROR_CAL_ACTIVE && (REJECT == '0) && (SETPOINTS == $past(SETPOINTS))
    ) else $error("error save did more than commit");

    a_range_session_open: assert property (
        CE && (req.op == OP_RANGE_SET) |=> RANGE_CAL_ACTIVE
    ) else $error("range set did not open the session");

    a_error_session_open: assert property (
        CE && (req.op == OP_ERROR_SET) |=> ERROR_CAL_ACTIVE
    ) else $error("error set did not open the session");

    a_ignored_pulse: assert property (
        CE && drop |=> IGNORED
    ) else $error("dropped frame not flagged");

    generate
        for (gi = 0; gi < NUM_IN; gi++) begin : g_chk
            a_range_order: assert property (
                SETPOINTS[gi].range_min <= SETPOINTS[gi].range_max
            ) else $error("range minimum above range maximum");

            a_error_order: assert property (
                SETPOINTS[gi].error_min <= SETPOINTS[gi].error_max
            ) else $error("error minimum above error maximum");

            a_range_max_cap: assert property (
                CE && (req.op == OP_RANGE_SET) && req.mask[gi] && req.maxsel
                && (req.value > setpt_t'({1'b0, MAX_CAP[gi]}))
                |=> REJECT[gi] && !ACCEPT[gi]
            ) else $error("range maximum above capacity accepted");

            a_error_max_cap: assert property (
                CE && (req.op == OP_ERROR_SET) && req.mask[gi] && req.maxsel
                && (req.value > setpt_t'({1'b0, MAX_CAP[gi]}))
                |=> REJECT[gi] && !ACCEPT[gi]
            ) else $error("error maximum above capacity accepted");

            a_reject_holds: assert property (
                REJECT[gi] |-> (SETPOINTS[gi] == $past(SETPOINTS[gi]))
            ) else $error("rejected value changed a setpoint");

            a_mask_unselected: assert property (
                CE && !req.mask[gi]
                |=> !ACCEPT[gi] && !REJECT[gi] && (SETPOINTS[gi] == $past(SETPOINTS[gi]))
            ) else $error("unselected input was touched");

            a_range_min_cap: assert property (
                CE && (req.op == OP_RANGE_SET) && req.mask[gi] && !req.maxsel
                && (req.value < -setpt_t'({1'b0, MAX_CAP[gi]}))
                |=> REJECT[gi] && !ACCEPT[gi]
            ) else $error("range minimum below minus capacity accepted");

            a_error_min_cap: assert property (
                CE && (req.op == OP_ERROR_SET) && req.mask[gi] && !req.maxsel
                && (req.value < -setpt_t'({1'b0, MAX_CAP[gi]}))
                |=> REJECT[gi] && !ACCEPT[gi]
            ) else $error("error minimum below minus capacity accepted");

            a_range_max_store: assert property (
                CE && (req.op == OP_RANGE_SET) && req.mask[gi] && req.maxsel
                |=> !ACCEPT[gi] || (SETPOINTS[gi].range_max == $past(req.value))
            ) else $error("accepted range maximum not stored");

            a_range_min_store: assert property (
                CE && (req.op == OP_RANGE_SET) && req.mask[gi] && !req.maxsel
                |=> !ACCEPT[gi] || (SETPOINTS[gi].range_min == $past(req.value))
            ) else $error("accepted range minimum not stored");

            a_error_min_store: assert property (
                CE && (req.op == OP_ERROR_SET) && req.mask[gi] && !req.maxsel
                |=> !ACCEPT[gi] || (SETPOINTS[gi].error_min == $past(req.value))
            ) else $error("accepted error minimum not stored");
        end
    endgenerate

    c_range_accept: cover property (
        (req.op == OP_RANGE_SET) && CE ##1 (ACCEPT != '0)
    );

    c_error_reject: cover property (
        (req.op == OP_ERROR_SET) && CE ##1 (REJECT != '0)
    );

    c_multi_input: cover property (
        ACCEPT == '1
    );

    c_session_commit: cover property (
        RANGE_CAL_ACTIVE ##[1:20] SAVE_RANGE
    );

    c_error_commit: cover property (
        ERROR_CAL_ACTIVE ##[1:20] SAVE_ERROR
    );

endmodule
`default_nettype wire

/* File: sim/cal_host_model.sv */
// Host side model: presents calibration frames as the CAN controller would hand them over.
// Assumes it is called just after a rising clock edge and that the caller orders frames.
`timescale 1ns/1ps
`default_nettype none
module cal_host_model
    import cal_pkg::*;
(
    // Clock
    input wire logic clk,
    // Frame towards the decoder
    output var can_msg_s msg
);
    initial begin
        msg = '0;
    end

    // Holds the frame for one sampling edge; back to back when last is clear
    task automatic send(input logic [7:0] cmd, input logic [7:0] opt, input logic [7:0] sign,
                        input logic [MAG_W-1:0] mag, input logic [LEN_W-1:0] len,
                        input logic [PGN_W-1:0] pgn, input bit last);
        msg.valid = 1'b1;
        msg.pgn = pgn;
        msg.len = len;
        msg.data = {mag[7:0], mag[15:8], mag[23:16], sign, opt, cmd};
        @(posedge clk);
        #1;
        if (last) begin
            msg.valid = 1'b0;
            // Released bytes must not keep the last value
            msg.data = ~msg.data;
        end
    endtask
endmodule
`default_nettype wire

/* File: sim/tb_cal_cmd_ctrl.sv */
// Self-checking bench for the calibration command handler, compared with a queue-based model.
// Assumes outputs answer after the first edge that follows a frame's taking edge, and CE held high.
`timescale 1ns/1ps
`default_nettype none
module tb_cal_cmd_ctrl;
    import cal_pkg::*;

    typedef struct packed {
        logic [7:0] cmd;
        logic [7:0] opt;
        logic [7:0] sign;
        logic [MAG_W-1:0] mag;
        logic [LEN_W-1:0] len;
        logic [PGN_W-1:0] pgn;
    } frame_s;

    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [PGN_W-1:0] pgn_sel = PGN_DEFAULT;
    logic [NUM_IN-1:0][MAG_W-1:0] max_cap = '0;
    can_msg_s msg;
    chan_setpt_s [NUM_IN-1:0] setpoints;
    logic [NUM_IN-1:0] accept;
    logic [NUM_IN-1:0] reject;
    logic ignored;
    logic range_act;
    logic error_act;
    logic save_range;
    logic save_error;
    int miscompares = 0;
    int checks_done = 0;
    int rmin[NUM_IN];
    int rmax[NUM_IN];
    int emin[NUM_IN];
    int emax[NUM_IN];
    logic [NUM_IN-1:0] x_acc = '0;
    logic [NUM_IN-1:0] x_rej = '0;
    logic x_ign = 1'b0;
    logic x_sr = 1'b0;
    logic x_se = 1'b0;
    logic x_ra = 1'b0;
    logic x_ea = 1'b0;
    frame_s fq[$];
    logic [7:0] codes[4] = '{CMD_RANGE_SET, CMD_RANGE_SAVE, CMD_ERROR_SET, CMD_ERROR_SAVE};

    always #2 clk = ~clk;

    cal_host_model i_cal_host_model (.clk(clk), .msg(msg));

    cal_cmd_ctrl i_cal_cmd_ctrl (.CLK(clk), .RST(rst), .CE(1'b1), .MSG(msg), .PGN_SEL(pgn_sel),
        .MAX_CAP(max_cap), .SETPOINTS(setpoints), .ACCEPT(accept), .REJECT(reject),
        .IGNORED(ignored), .RANGE_CAL_ACTIVE(range_act), .ERROR_CAL_ACTIVE(error_act),
        .SAVE_RANGE(save_range), .SAVE_ERROR(save_error));

    task automatic complete_run();
        $display("miscompares %0d checks_done %0d", miscompares, checks_done);
        if (miscompares == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input logic [VAL_W-1:0] got, input logic [VAL_W-1:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic model(input frame_s f);
        int v;
        int lo;
        int hi;
        bit er;
        x_acc = '0;
        x_rej = '0;
        x_ign = 1'b0;
        x_sr = 1'b0;
        x_se = 1'b0;
        if (f.pgn !== pgn_sel) return;
        if (f.len != MSG_LEN) begin
            x_ign = 1'b1;
            return;
        end
        if (f.cmd == CMD_RANGE_SAVE) begin
            x_sr = 1'b1;
            x_ra = 1'b0;
        end else if (f.cmd == CMD_ERROR_SAVE) begin
            x_se = 1'b1;
            x_ea = 1'b0;
        end else if ((f.cmd != CMD_RANGE_SET && f.cmd != CMD_ERROR_SET) || f.sign > SIGN_NEG) begin
            x_ign = 1'b1;
        end else begin
            er = (f.cmd == CMD_ERROR_SET);
            v = (f.sign == SIGN_NEG) ? -int'(f.mag) : int'(f.mag);
            if (er) x_ea = 1'b1;
            else x_ra = 1'b1;
            for (int i = 0; i < NUM_IN; i++) begin
                if (f.opt[i]) begin
                    lo = f.opt[MAXSEL_BIT] ? (er ? emin[i] : rmin[i]) : -int'(max_cap[i]);
                    hi = f.opt[MAXSEL_BIT] ? int'(max_cap[i]) : (er ? emax[i] : rmax[i]);
                    if (v < lo || v > hi) begin
                        x_rej[i] = 1'b1;
                    end else begin
                        x_acc[i] = 1'b1;
                        case ({er, f.opt[MAXSEL_BIT]})
                            2'b00: rmin[i] = v;
                            2'b01: rmax[i] = v;
                            2'b10: emin[i] = v;
                            default: emax[i] = v;
                        endcase
                    end
                end
            end
        end
    endtask

    task automatic compare_all();
        chk(accept, x_acc);
        chk(reject, x_rej);
        chk(ignored, x_ign);
        chk(save_range, x_sr);
        chk(save_error, x_se);
        chk(range_act, x_ra);
        chk(error_act, x_ea);
        for (int i = 0; i < NUM_IN; i++) begin
            chk(setpoints[i].range_min, setpt_t'(rmin[i]));
            chk(setpoints[i].range_max, setpt_t'(rmax[i]));
            chk(setpoints[i].error_min, setpt_t'(emin[i]));
            chk(setpoints[i].error_max, setpt_t'(emax[i]));
        end
    endtask

    task automatic add(input logic [7:0] c, input logic [7:0] o, input logic [7:0] s, input logic [MAG_W-1:0] m,
                       input logic [LEN_W-1:0] l = MSG_LEN, input logic [PGN_W-1:0] p = PGN_DEFAULT);
        fq.push_back({c, o, s, m, l, p});
    endtask

    // Sends up to two queued frames back to back, then checks each answer and the quiet cycle
    task automatic run();
        int n;
        frame_s idle;
        n = fq.size();
        for (int k = 0; k < n; k++)
            i_cal_host_model.send(fq[k].cmd, fq[k].opt, fq[k].sign, fq[k].mag, fq[k].len, fq[k].pgn, k == n - 1);
        repeat (2 - n) @(posedge clk);
        for (int k = 0; k < n; k++) begin
            if (k > 0) @(posedge clk);
            #1;
            model(fq[k]);
            compare_all();
        end
        @(posedge clk);
        #1;
        idle = '0;
        idle.pgn = ~pgn_sel;
        model(idle);
        compare_all();
        fq.delete();
    endtask

    initial begin
        #50000;
        miscompares++;
        complete_run();
    end

    initial begin
        void'($urandom(9083));
        for (int i = 0; i < NUM_IN; i++) begin
            rmin[i] = 0;
            rmax[i] = 0;
            emin[i] = 0;
            emax[i] = 0;
        end
        repeat (12) @(posedge clk);
        #1;
        rst = 1'b0;
        compare_all();
        max_cap = {24'h000dac, 24'h01adb0, 24'hffffff, 24'h000100};
        add(CMD_RANGE_SET, 8'h14, SIGN_POS, 24'h01adb0); run();
        add(CMD_RANGE_SET, 8'h04, SIGN_NEG, 24'h000032); run();
        add(CMD_RANGE_SET, 8'h14, SIGN_POS, 24'h01adb1); run();
        add(CMD_RANGE_SET, 8'h04, SIGN_NEG, 24'h01adb1); run();
        add(CMD_ERROR_SET, 8'h08, SIGN_NEG, 24'h000dac); run();
        add(CMD_ERROR_SET, 8'h18, SIGN_POS, 24'h000dac); run();
        add(CMD_ERROR_SET, 8'h08, SIGN_POS, 24'h000dad); run();
        add(CMD_RANGE_SAVE, 8'hff, 8'h77, 24'h123456); run();
        add(CMD_ERROR_SAVE, 8'h1f, 8'h02, 24'hffffff); run();
        add(CMD_RANGE_SET, 8'h0f, SIGN_POS, 24'h000010, 4'h5); run();
        add(8'hac, 8'h0f, SIGN_POS, 24'h000010); run();
        add(CMD_ERROR_SET, 8'h1f, 8'h02, 24'h000010); run();
        add(CMD_RANGE_SET, 8'h1f, SIGN_POS, 24'h000010, MSG_LEN, 18'h0ff00); run();
        add(CMD_RANGE_SET, 8'h13, SIGN_POS, 24'h000080); add(CMD_RANGE_SET, 8'h03, SIGN_POS, 24'h000080); run();
        add(CMD_RANGE_SAVE, 8'h00, 8'h00, 24'h0); add(CMD_ERROR_SET, 8'h1a, SIGN_POS, 24'h000400); run();
        pgn_sel = 18'h0ff10;
        add(CMD_ERROR_SET, 8'h0f, SIGN_NEG, 24'h000020, MSG_LEN, 18'h0ff10); run();
        add(CMD_ERROR_SET, 8'h0f, SIGN_NEG, 24'h000040); run();
        pgn_sel = PGN_DEFAULT;
        rst = 1'b1;
        @(posedge clk);
        #1;
        rst = 1'b0;
        x_ra = 1'b0;
        x_ea = 1'b0;
        for (int i = 0; i < NUM_IN; i++) begin
            rmin[i] = 0;
            rmax[i] = 0;
            emin[i] = 0;
            emax[i] = 0;
        end
        compare_all();
        repeat (60) begin
            for (int i = 0; i < NUM_IN; i++) max_cap[i] = 24'($urandom_range(0, 24'h020000));
            add(codes[$urandom_range(0, 3)], 8'($urandom_range(0, 31)), 8'($urandom_range(0, 1)),
                24'($urandom_range(0, 24'h020000)));
            if ($urandom_range(0, 1) == 1)
                add(codes[$urandom_range(0, 3)], 8'($urandom_range(0, 31)), 8'($urandom_range(0, 1)),
                    24'($urandom_range(0, 24'h020000)));
            run();
        end
        complete_run();
    end
endmodule
`default_nettype wire
